// ---- logic/bus_cycle_if.sv ----
// internal bus cycle signals shared by the trace and monitor
`timescale 1ns/1ps
interface bus_cycle_if;
    logic start;
    logic term;
    logic external;
    logic tmo;
    modport src (output start, output term, output external, input tmo);
    modport mon (input start, input term, input external, output tmo);
endinterface

// ---- logic/bus_timeout_monitor.sv ----
// bus timeout monitor
`timescale 1ns/1ps
`include "bus_trace_defines.svh"
module bus_timeout_monitor (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // config
    input wire logic [1:0] tmo_sel_in,
    input wire logic ext_en_in,
    input wire logic dbg_dis_in,
    input wire logic in_debug_in,
    // cycle
    bus_cycle_if.mon cyc
);
    logic [6:0] cnt_ff;
    logic busy_ff;
    logic tmo_ff;
    logic [6:0] limit;
    logic watch;

    // ===========================================
    // limit select
    always_comb begin
        case (tmo_sel_in)
            2'b00: limit = `BT_TMO_LIM0;
            2'b01: limit = `BT_TMO_LIM1;
            2'b10: limit = `BT_TMO_LIM2;
            default: limit = `BT_TMO_LIM3;
        endcase
    end
    assign watch = (ext_en_in || !cyc.external) && !(dbg_dis_in && in_debug_in);
    assign cyc.tmo = tmo_ff;

    // ===========================================
    // counter
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt_ff <= 7'h00;
            busy_ff <= 1'b0;
            tmo_ff <= 1'b0;
        end else if (ce_in) begin
            tmo_ff <= 1'b0;
            if (cyc.start) begin
                cnt_ff <= 7'h00;
                busy_ff <= 1'b1;
            end else if (cyc.term || tmo_ff) begin
                busy_ff <= 1'b0;
            end else if (busy_ff && watch) begin
                cnt_ff <= cnt_ff + 7'h01;
                if (cnt_ff + 7'h01 >= limit) begin
                    tmo_ff <= 1'b1;
                    busy_ff <= 1'b0;
                end
            end
        end
    end

    property p_tmo_bound;
        @(posedge mclk_in) disable iff (sys_rst_in) $rose(tmo_ff) |-> $past(cnt_ff) + 7'h01 >= limit;
    endproperty
    a_tmo_bound: assert property (p_tmo_bound) else $error("timeout before limit");
    property p_restart;
        @(posedge mclk_in) disable iff (sys_rst_in) (ce_in && cyc.start) |=> cnt_ff == 7'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");
    property p_ext_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && busy_ff && cyc.external && !ext_en_in && !cyc.start) |=> $stable(cnt_ff);
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external counted when off");
    property p_dbg;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && dbg_dis_in && in_debug_in && !cyc.start) |=> $stable(cnt_ff);
    endproperty
    a_dbg: assert property (p_dbg) else $error("counted in debug");
endmodule

// ---- logic/bus_trace.sv ----
// show strobe, trace pins and bus monitor top
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "bus_trace_defines.svh"
module bus_trace (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // mode and configuration
    input wire logic emul_mode_in,
    input wire logic show_strobe_gpio_in,
    input wire logic show_cycle_enable_in,
    input wire logic [2:0] trace_pin_assign_in,
    input wire logic status_output_enable_in,
    input wire logic [1:0] monitor_timeout_select_in,
    input wire logic monitor_external_enable_in,
    input wire logic monitor_debug_disable_in,
    // internal bus
    input wire logic cyc_start_in,
    input wire logic [31:0] addr_in,
    input wire logic rw_in,
    input wire logic [1:0] size_in,
    input wire logic supervisor_in,
    input wire bus_trace_pkg::access_kind_t kind_in,
    input wire logic xfer_ack_in,
    input wire logic ext_err_in,
    input wire logic [31:0] rdata_in,
    input wire logic [3:0] core_status_in,
    // trace pins
    output logic show_strobe_out,
    output logic show_strobe_oe_out,
    output logic [31:0] addr_out,
    output logic rw_out,
    output logic [1:0] transfer_size_out,
    output logic [2:0] transfer_code_out,
    output logic transfer_code_oe_out,
    output logic [1:0] emulation_chip_select_out,
    output logic [3:0] core_status_code_out,
    output logic core_status_oe_out,
    output logic [31:0] data_out,
    output logic data_oe_out,
    output logic oe_n_out,
    output logic [3:0] byte_enable_pins_n_out,
    // termination
    output logic xfer_done_out,
    output logic xfer_err_ack_out
);
    import bus_trace_pkg::*;

    strobe_state_t state_ff;
    logic ext_ff;
    logic [31:0] addr_ff;
    logic [31:0] data_ff;
    bus_cycle_if cyc ();

    logic is_ext;
    assign is_ext = addr_in >= `BT_ADDR_EXT_LO;
    assign cyc.start = cyc_start_in;
    assign cyc.external = ext_ff;
    assign cyc.term = xfer_ack_in || ext_err_in;

    bus_timeout_monitor u_mon (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .tmo_sel_in(monitor_timeout_select_in),
        .ext_en_in(monitor_external_enable_in),
        .dbg_dis_in(monitor_debug_disable_in),
        .in_debug_in(core_status_in == `BT_PST_DEBUG),
        .cyc(cyc)
    );

    // ===========================================
    // strobe sequence
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_ff <= ST_IDLE;
            show_strobe_out <= 1'b1;
            ext_ff <= 1'b0;
        end else if (ce_in) begin
            case (state_ff)
                ST_IDLE: begin
                    if (cyc_start_in) begin
                        state_ff <= ST_ADDR;
                        show_strobe_out <= 1'b0;
                        ext_ff <= is_ext;
                    end
                end
                ST_ADDR, ST_WAIT: begin
                    if (cyc.term || cyc.tmo) begin
                        state_ff <= ST_DATA;
                        show_strobe_out <= 1'b1;
                    end else begin
                        state_ff <= ST_WAIT;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ===========================================
    // address phase pins
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            addr_ff <= 32'h0000_0000;
            addr_out <= 32'h0000_0000;
            rw_out <= 1'b1;
            transfer_size_out <= 2'h0;
            transfer_code_out <= 3'h0;
            emulation_chip_select_out <= `BT_CSE_REGS;
        end else if (ce_in && cyc_start_in && state_ff == ST_IDLE) begin
            addr_ff <= addr_in;
            addr_out <= addr_in;
            rw_out <= rw_in;
            transfer_size_out <= size_in;
            transfer_code_out <= {supervisor_in, kind_in};
            if (addr_in >= `BT_ADDR_PORT_LO && addr_in <= `BT_ADDR_PORT_HI) begin
                emulation_chip_select_out <= `BT_CSE_PORTS;
            end else if (addr_in >= `BT_ADDR_REG_LO && addr_in <= `BT_ADDR_REG_HI) begin
                emulation_chip_select_out <= `BT_CSE_REGS;
            end else if (is_ext) begin
                emulation_chip_select_out <= `BT_CSE_EXT;
            end else begin
                emulation_chip_select_out <= `BT_CSE_INT;
            end
        end
    end

    // ===========================================
    // enables and status
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            show_strobe_oe_out <= 1'b1;
            transfer_code_oe_out <= 1'b0;
            core_status_oe_out <= 1'b0;
            core_status_code_out <= 4'h0;
            oe_n_out <= 1'b1;
            byte_enable_pins_n_out <= 4'hf;
        end else if (ce_in) begin
            show_strobe_oe_out <= emul_mode_in || !show_strobe_gpio_in;
            transfer_code_oe_out <= emul_mode_in || (trace_pin_assign_in == 3'h7);
            core_status_oe_out <= emul_mode_in || status_output_enable_in;
            core_status_code_out <= core_status_in;
            oe_n_out <= !(state_ff != ST_IDLE && ext_ff && rw_out);
            byte_enable_pins_n_out <= (state_ff != ST_IDLE && ext_ff) ? 4'h0 : 4'hf;
        end
    end

    // ===========================================
    // data and termination
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            data_out <= 32'h0000_0000;
            data_oe_out <= 1'b0;
            data_ff <= 32'h0000_0000;
            xfer_done_out <= 1'b0;
            xfer_err_ack_out <= 1'b0;
        end else if (ce_in) begin
            xfer_done_out <= 1'b0;
            xfer_err_ack_out <= 1'b0;
            data_oe_out <= 1'b0;
            if ((state_ff == ST_ADDR || state_ff == ST_WAIT) && (cyc.term || cyc.tmo)) begin
                data_ff <= rdata_in;
                data_out <= rdata_in;
                data_oe_out <= !ext_ff && (show_cycle_enable_in || emul_mode_in);
                xfer_err_ack_out <= cyc.tmo || ext_err_in;
                xfer_done_out <= xfer_ack_in && !cyc.tmo && !ext_err_in;
            end
        end
    end

    // ===========================================
    // assertions
    sequence s_addr;
        !show_strobe_out ##0 state_ff == ST_ADDR;
    endsequence
    sequence s_data;
        show_strobe_out ##1 show_strobe_out;
    endsequence
    sequence s_take;
        ce_in && cyc_start_in && state_ff == ST_IDLE;
    endsequence
    sequence s_end;
        ce_in && (state_ff == ST_ADDR || state_ff == ST_WAIT) && (cyc.term || cyc.tmo);
    endsequence

    property p_one_pulse;
        @(posedge mclk_in) disable iff (sys_rst_in)
            $rose(show_strobe_out) |-> s_data;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("strobe pulse wrong");
    property p_strobe_term;
        @(posedge mclk_in) disable iff (sys_rst_in)
            $rose(show_strobe_out) |-> (xfer_done_out || xfer_err_ack_out);
    endproperty
    a_strobe_term: assert property (p_strobe_term) else $error("strobe high without end");
    property p_err_wins;
        @(posedge mclk_in) disable iff (sys_rst_in) xfer_err_ack_out |-> !xfer_done_out;
    endproperty
    a_err_wins: assert property (p_err_wins) else $error("ack beat error");
    property p_show_neg;
        @(posedge mclk_in) disable iff (sys_rst_in) (data_oe_out && !ext_ff) |-> byte_enable_pins_n_out == 4'hf;
    endproperty
    a_show_neg: assert property (p_show_neg) else $error("byte enables in show cycle");
    property p_cse_ports;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && cyc_start_in && state_ff == ST_IDLE && addr_in[31:16] == 16'h00c0)
            |=> emulation_chip_select_out == 2'h2;
    endproperty
    a_cse_ports: assert property (p_cse_ports) else $error("port select wrong");
    property p_pst_oe;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && emul_mode_in) |=> core_status_oe_out;
    endproperty
    a_pst_oe: assert property (p_pst_oe) else $error("status pins off in emulation");

    property p_fall_start;
        @(posedge mclk_in) disable iff (sys_rst_in)
            $fell(show_strobe_out) |-> s_addr;
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("strobe fell outside a cycle");

    property p_strobe_low;
        @(posedge mclk_in) disable iff (sys_rst_in)
            !show_strobe_out |-> (state_ff == ST_ADDR || state_ff == ST_WAIT);
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe low while idle");

    property p_tc_code;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_take |=> transfer_code_out == {$past(supervisor_in), $past(kind_in)};
    endproperty
    a_tc_code: assert property (p_tc_code) else $error("transfer code wrong");

    property p_cse_ext;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_take ##0 (addr_in >= `BT_ADDR_EXT_LO) |=> emulation_chip_select_out == `BT_CSE_EXT;
    endproperty
    a_cse_ext: assert property (p_cse_ext) else $error("external select wrong");

    property p_cse_regs;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_take ##0 (addr_in >= `BT_ADDR_REG_LO && addr_in <= `BT_ADDR_REG_HI)
            |=> emulation_chip_select_out == `BT_CSE_REGS;
    endproperty
    a_cse_regs: assert property (p_cse_regs) else $error("register select wrong");

    property p_cse_int;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_take ##0 (addr_in < `BT_ADDR_PORT_LO) |=> emulation_chip_select_out == `BT_CSE_INT;
    endproperty
    a_cse_int: assert property (p_cse_int) else $error("internal select wrong");

    property p_code_oe;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && emul_mode_in) |=> transfer_code_oe_out;
    endproperty
    a_code_oe: assert property (p_code_oe) else $error("code pins off in emulation");

    property p_strobe_oe;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (ce_in && emul_mode_in) |=> show_strobe_oe_out;
    endproperty
    a_strobe_oe: assert property (p_strobe_oe) else $error("strobe pin off in emulation");

    property p_status_follow;
        @(posedge mclk_in) disable iff (sys_rst_in)
            ce_in |=> core_status_code_out == $past(core_status_in);
    endproperty
    a_status_follow: assert property (p_status_follow) else $error("status code not passed");

    property p_show_data;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (data_oe_out && $past(ce_in)) |-> data_out == $past(rdata_in);
    endproperty
    a_show_data: assert property (p_show_data) else $error("show data wrong");

    property p_show_oe_n;
        @(posedge mclk_in) disable iff (sys_rst_in)
            data_oe_out |-> oe_n_out;
    endproperty
    a_show_oe_n: assert property (p_show_oe_n) else $error("output enable in show cycle");

    property p_tmo_err;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_end ##0 cyc.tmo |=> (xfer_err_ack_out && !xfer_done_out);
    endproperty
    a_tmo_err: assert property (p_tmo_err) else $error("timeout not reported as error");

    property p_ack_done;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_end ##0 (xfer_ack_in && !ext_err_in && !cyc.tmo) |=> xfer_done_out;
    endproperty
    a_ack_done: assert property (p_ack_done) else $error("acknowledge lost");

    property p_rise_end;
        @(posedge mclk_in) disable iff (sys_rst_in)
            s_end |=> show_strobe_out;
    endproperty
    a_rise_end: assert property (p_rise_end) else $error("strobe not raised at end");

    property p_hold_addr;
        @(posedge mclk_in) disable iff (sys_rst_in)
            (!show_strobe_out && $past(!show_strobe_out)) |-> $stable(addr_out);
    endproperty
    a_hold_addr: assert property (p_hold_addr) else $error("address moved in cycle");
endmodule

// ---- logic/bus_trace_defines.svh ----
// constants for the bus trace and bus monitor block
// Operation
// - show strobe low when address/code/size/rw/select/status valid, high when data valid
// - show strobe pulses low then high exactly once per bus cycle
// - show strobe enabled after reset; master mode may turn pin into digital io
// - transfer code driven by default in emulation mode, else when pin-assign selects
// - user codes: 000 data, 001 reserved, 010 instruction, 011 change of flow
// - supervisor codes: 100 data, 101 vector, 110 instruction, 111 change of flow
// - load-relative-word is instruction; taken flow changes and table fetches use flow codes
// - core status on four pins by default in emulation, else when status enable set
// - non-launch status: stalled 0000/0001/0101, exception 0010, low power 0100, debug 0110
// - launch status: 1000..1101 and 1111 per instruction class, 1110 reserved
// - count clocks awaiting termination; bus error when count reaches limit
// - four limits 8, 16, 32, 64 clocks chosen by two-bit select
// - counter cleared and restarted at every access; expiry terminates the cycle
// - scope bit chooses internal only or internal and external accesses
// - monitor may be disabled while the core is in debug mode
// - split 32-bit access to 16-bit port timed as two separate cycles
// - no interrupt request; timeout only reported as bus error termination
// - show cycle keeps output enable and byte enables negated; data on clock after end
// - emulation select 10 ports, 11 other registers, 01 other internal, 00 external
// - timeout asserts internal error acknowledge, which beats normal acknowledge
`ifndef BUS_TRACE_DEFINES_SVH
`define BUS_TRACE_DEFINES_SVH
`define BT_TMO_LIM0 7'h08
`define BT_TMO_LIM1 7'h10
`define BT_TMO_LIM2 7'h20
`define BT_TMO_LIM3 7'h40
`define BT_CSE_PORTS 2'h2
`define BT_CSE_REGS 2'h3
`define BT_CSE_INT 2'h1
`define BT_CSE_EXT 2'h0
`define BT_ADDR_PORT_LO 32'h00c0_0000
`define BT_ADDR_PORT_HI 32'h00c0_ffff
`define BT_ADDR_REG_LO 32'h00c1_0000
`define BT_ADDR_REG_HI 32'h00ff_ffff
`define BT_ADDR_EXT_LO 32'h8000_0000
`define BT_PST_DEBUG 4'h6
`endif

// ---- logic/bus_trace_pkg.sv ----
// types for the bus trace and bus monitor block
package bus_trace_pkg;
    typedef enum logic [1:0] {
        ACC_DATA = 2'b00,
        ACC_VECTOR = 2'b01,
        ACC_INSTR = 2'b10,
        ACC_FLOW = 2'b11
    } access_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WAIT = 2'b10,
        ST_DATA = 2'b11
    } strobe_state_t;
endpackage

// ---- testbench/emu_latch.sv ----
// emulator model latching the trace pins on the show strobe
`timescale 1ns/1ps
module emu_latch (
    // pins
    input wire logic mclk_in,
    input wire logic show_strobe_in,
    input wire logic [31:0] addr_in,
    input wire logic [2:0] code_in,
    input wire logic [1:0] cse_in,
    input wire logic [31:0] data_in,
    // latched view
    output int falls_out,
    output logic [31:0] addr_out,
    output logic [2:0] code_out,
    output logic [1:0] cse_out,
    output logic [31:0] data_out
);
    logic prev_ff = 1'b1;
    initial falls_out = 0;
    // ===========================================
    // latch address side on fall, data on rise
    always @(posedge mclk_in) begin
        prev_ff <= show_strobe_in;
        if (prev_ff && !show_strobe_in) begin
            falls_out <= falls_out + 1;
            addr_out <= addr_in;
            code_out <= code_in;
            cse_out <= cse_in;
        end
        if (!prev_ff && show_strobe_in) begin
            data_out <= data_in;
        end
    end
endmodule

// ---- testbench/tb_bus_trace_and_bus_monitor.sv ----
// self-checking bench for the bus trace and monitor
`timescale 1ns/1ps
module tb_bus_trace_and_bus_monitor;
    import bus_trace_pkg::*;
    logic mclk_in, sys_rst_in, ce_in, emul_mode_in, show_strobe_gpio_in, show_cycle_enable_in;
    logic status_output_enable_in, monitor_external_enable_in, monitor_debug_disable_in;
    logic cyc_start_in, rw_in, supervisor_in, xfer_ack_in, ext_err_in;
    logic [2:0] trace_pin_assign_in, transfer_code_out, l_code;
    logic [1:0] monitor_timeout_select_in, size_in, transfer_size_out, emulation_chip_select_out, l_cse;
    logic [31:0] addr_in, rdata_in, addr_out, data_out, l_addr, l_data;
    logic [3:0] core_status_in, core_status_code_out, byte_enable_pins_n_out;
    access_kind_t kind_in;
    logic show_strobe_out, show_strobe_oe_out, rw_out, transfer_code_oe_out, core_status_oe_out;
    logic data_oe_out, oe_n_out, xfer_done_out, xfer_err_ack_out;
    logic [31:0] exp_q[$];
    int falls, miscompares = 0, cmp_count = 0;
    bus_trace dut (.*);
    emu_latch emu (.mclk_in, .show_strobe_in(show_strobe_out), .addr_in(addr_out), .code_in(transfer_code_out),
        .cse_in(emulation_chip_select_out), .data_in(data_out), .falls_out(falls), .addr_out(l_addr),
        .code_out(l_code), .cse_out(l_cse), .data_out(l_data));
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // ===========================================
    // model and checking
    function automatic logic [1:0] exp_cse(logic [31:0] a);
        if (a >= 32'h8000_0000) return 2'h0;
        if (a >= 32'h00c0_0000 && a <= 32'h00c0_ffff) return 2'h2;
        if (a >= 32'h00c1_0000 && a <= 32'h00ff_ffff) return 2'h3;
        return 2'h1;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one bus cycle; waits < 0 leaves it to the monitor
    task automatic run_cycle(input logic [31:0] a, input int waits, input logic err);
        logic [31:0] d;
        logic exp_err;
        int n, f0, lim;
        d = $urandom;
        f0 = falls;
        exp_err = err || (waits < 0);
        @(posedge mclk_in);
        lim = 8 << monitor_timeout_select_in;
        cyc_start_in <= 1'b1;
        addr_in <= a;
        {supervisor_in, rw_in, size_in} <= d[3:0];
        kind_in <= access_kind_t'(d[5:4]);
        rdata_in <= d;
        exp_q.push_back(d);
        for (n = 0; n < 100; n++) begin
            @(posedge mclk_in);
            cyc_start_in <= 1'b0;
            xfer_ack_in <= (n == waits) && !err;
            ext_err_in <= (n == waits) && err;
            #1;
            if (xfer_done_out === 1'b1 || xfer_err_ack_out === 1'b1) break;
        end
        if (n == 100) begin
            miscompares++;
            conclude();
        end
        if (waits < 0) check("latency_ok", 1, n >= lim && n <= lim + 3);
        check("err_ack", exp_err, xfer_err_ack_out);
        check("done", !exp_err, xfer_done_out);
        check("rw", d[2], rw_out);
        check("size", d[1:0], transfer_size_out);
        if (a < 32'h8000_0000) check("oe_be", 5'h1f, {oe_n_out, byte_enable_pins_n_out});
        check("data_oe", a < 32'h8000_0000, data_oe_out);
        if (a < 32'h8000_0000 && !exp_err) check("data", exp_q[0], data_out);
        @(posedge mclk_in);
        #1;
        check("falls", f0 + 1, falls);
        check("l_addr", a, l_addr);
        check("l_code", {d[3], d[5:4]}, l_code);
        check("l_cse", exp_cse(a), l_cse);
        if (a < 32'h8000_0000 && !exp_err) check("l_data", exp_q[0], l_data);
        void'(exp_q.pop_front());
        @(posedge mclk_in);
    endtask
    // ===========================================
    // main sequence
    initial begin
        logic [31:0] bases [4];
        bases = '{32'h00c0_0000, 32'h00c1_0000, 32'h0000_0000, 32'h8000_0000};
        void'($urandom(32'he8483bed));
        {ce_in, sys_rst_in, emul_mode_in, show_cycle_enable_in, status_output_enable_in} = 5'h1f;
        {show_strobe_gpio_in, monitor_debug_disable_in, cyc_start_in, xfer_ack_in, ext_err_in} = 5'h0;
        {monitor_external_enable_in, trace_pin_assign_in, monitor_timeout_select_in} = 6'h1c;
        {rw_in, supervisor_in, size_in, addr_in, rdata_in, kind_in} = '0;
        core_status_in = 4'h8;
        repeat (20) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        #1;
        check("rst_pins", 8'hff, {show_strobe_out, show_strobe_oe_out, emulation_chip_select_out,
            byte_enable_pins_n_out});
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            {emul_mode_in, show_strobe_gpio_in, status_output_enable_in} <= 3'(i);
            trace_pin_assign_in <= i[3] ? 3'h7 : 3'(i);
            repeat (2) @(posedge mclk_in);
            #1;
            check("strobe_oe", emul_mode_in | !show_strobe_gpio_in, show_strobe_oe_out);
            check("code_oe", emul_mode_in | i[3], transfer_code_oe_out);
            check("status_oe", emul_mode_in | status_output_enable_in, core_status_oe_out);
        end
        @(posedge mclk_in);
        {emul_mode_in, show_strobe_gpio_in, trace_pin_assign_in} <= 5'h17;
        $display("test enables done");
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            core_status_in <= 4'(i);
            repeat (2) @(posedge mclk_in);
            #1;
            check("status", i, core_status_code_out);
        end
        core_status_in <= 4'h8;
        $display("test status done");
        for (int i = 0; i < 8; i++) run_cycle(bases[i % 4] | 32'($urandom_range(16'hffff)), i / 4 * 2, i == 7);
        $display("test cycles done");
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk_in);
            monitor_timeout_select_in <= 2'(s);
            run_cycle(32'h0000_1000, -1, 1'b0);
        end
        $display("test timeouts done");
        monitor_external_enable_in <= 1'b0;
        run_cycle(32'h9000_0000, 70, 1'b0);
        monitor_external_enable_in <= 1'b1;
        monitor_timeout_select_in <= 2'h0;
        repeat (2) run_cycle(32'h9000_0000, -1, 1'b0);
        $display("test scope done");
        core_status_in <= 4'h6;
        monitor_debug_disable_in <= 1'b1;
        run_cycle(32'h0000_2000, 20, 1'b0);
        $display("test debug done");
        conclude();
    end
endmodule
